// >>> inc/msm_pkg.sv
// msm_pkg: offsets, field positions, reset values and timing for the motion status monitor
// assumes a 32-bit APB register bus and a 200 MHz system clock
package msm_pkg;
  localparam int NUM_AXES = 32;
  localparam int WORDS_PER_AXIS = 4;
  // printed monitor offsets are word indices; byte address is four times the index
  localparam logic [15:0] MON_BASE_IDX = 16'h1F80;
  localparam logic [15:0] MON_LAST_IDX = 16'h1FFF;
  localparam logic [1:0] AMP_TYPE_IDX = 2'h0;
  localparam logic [1:0] CURRENT_IDX = 2'h1;
  localparam logic [1:0] SPEED_LO_IDX = 2'h2;
  localparam logic [1:0] SPEED_HI_IDX = 2'h3;
  // control and status registers, byte addresses
  localparam logic [15:0] STATUS_ADDR = 16'h0000;
  localparam logic [15:0] REQUEST_ADDR = 16'h0004;
  localparam logic [15:0] CAUSE_ADDR = 16'h0008;
  localparam logic [15:0] CYCLE_ADDR = 16'h000C;
  localparam logic [15:0] DECEL_ADDR = 16'h0010;
  localparam logic [15:0] CLEAR_ADDR = 16'h0014;
  // status flag bit positions
  localparam int WDOG_BIT = 0;
  localparam int READY_BIT = 1;
  localparam int TEST_BIT = 2;
  localparam int FSTOP_BIT = 3;
  localparam int HWHEEL_BIT = 4;
  localparam int TESTERR_BIT = 5;
  localparam int PROGERR_BIT = 6;
  localparam int SERVOERR_BIT = 7;
  localparam int SERVOON_BIT = 8;
  localparam int NUM_FLAGS = 7;
  // request word bits
  localparam int REQ_READY_BIT = 0;
  localparam int REQ_SERVOON_BIT = 1;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int MAIN_CYCLE_US = 100;
  localparam int MAIN_CYCLE_CYC = MAIN_CYCLE_US * CLK_MHZ;
  localparam int FAST_LIMIT_US = 1700;
  localparam int SLOW_REFRESH_US = 3500;
  localparam int SLOW_REFRESH_CYC = SLOW_REFRESH_US * CLK_MHZ;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] CYCLE_RESET_US = 32'h0000_0378;
  localparam logic [31:0] DECEL_RESET_US = 32'h0000_03E8;

  typedef struct packed {
    logic [15:0] ampType;
    logic [15:0] current;
    logic [31:0] speed;
  } msm_axis_s;

  typedef struct packed {
    logic wdogErr;
    logic [7:0] wdogCause;
    logic paramErr;
    logic handwheelErr;
    logic progErr;
    logic testReq;
    logic testActive;
    logic forcedStopIn;
    logic axesMoving;
  } msm_events_s;
endpackage

// >>> rtl/msm_sync.sv
// msm_sync: three-stage synchroniser for one pin input
// assumes the input is asynchronous to clk; the output changes once stages two and three agree
`timescale 1ns/1ps
module msm_sync import msm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pinIn,
  output logic levelOut
);
  logic [2:0] stage_ff;
  logic level_ff;

  // shift chain; stage 0 is only read by stage 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_ff <= 3'h0;
    end else begin
      stage_ff <= {stage_ff[1:0], pinIn};
    end
  end

  // accept a new level only when the two later stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b0;
    end else if (stage_ff[1] == stage_ff[2]) begin
      level_ff <= stage_ff[2];
    end
  end

  assign levelOut = level_ff;
endmodule // msm_sync

// >>> rtl/msm_tick.sv
// msm_tick: periodic one-cycle tick generator
// assumes a period of at least two cycles
`timescale 1ns/1ps
module msm_tick import msm_pkg::*; #(
  parameter int PERIOD = 20000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // tick out
  output logic tick
);
  logic [31:0] cnt_ff;
  logic tick_ff;

  // free-running count; tick fires as it wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;
endmodule // msm_tick

// >>> rtl/motion_status_monitor.sv
// motion_status_monitor: positioning status flags, per-axis servo monitor words, forced stop
// assumes an APB master on clk; servo-side values arrive as same-clock inputs,
// except the external forced-stop pin, which is asynchronous
`timescale 1ns/1ps
module motion_status_monitor import msm_pkg::*; #(
  parameter int MAIN_PERIOD = MAIN_CYCLE_CYC,
  parameter int SLOW_PERIOD = SLOW_REFRESH_CYC,
  parameter int CYC_PER_US = CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // servo-side monitor inputs
  input wire logic [NUM_AXES-1:0] ampPowerOn,
  input wire logic [NUM_AXES*16-1:0] ampTypeIn,
  input wire logic [NUM_AXES*16-1:0] currentIn,
  input wire logic [NUM_AXES*32-1:0] speedIn,
  input wire logic opCycleTick,
  // internal events and pin
  input wire msm_events_s events,
  input wire logic forcedStopPin,
  input wire logic [31:0] feedIn,
  // control outputs
  output logic immediateStop,
  output logic servoParamWrite,
  output logic mcodeClear,
  output logic allAxesServoOn,
  output logic [31:0] feedOut,
  output logic feedRestore
);
  msm_axis_s axis_ff [NUM_AXES];
  logic [NUM_FLAGS-1:0] live_ff;
  logic [NUM_FLAGS-1:0] shown_ff;
  logic [7:0] cause_ff;
  logic [31:0] request_ff;
  logic [31:0] cycleUs_ff;
  logic [31:0] decelUs_ff;
  logic hostReady_ff;
  logic readyCheck_ff;
  logic servoErr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] decelCnt_ff;
  logic [31:0] feedHold_ff;
  logic stopActive_ff;
  logic prevStop_ff;
  logic stopSync;
  logic mainTick;
  logic slowTick;
  logic refreshTick;
  logic wrEn;
  logic rdEn;
  logic monHit;
  logic [6:0] monAxis;
  logic [1:0] monWord;
  logic [15:0] monIdx;
  logic [31:0] decelCycles;
  logic stopEdge;
  logic releaseEdge;

  //////////////////////////////////////////////////////////////////////////
  // timing and pin conditioning
  msm_tick #(.PERIOD(MAIN_PERIOD)) mainGen (.clk(clk), .rst(rst), .tick(mainTick));
  msm_tick #(.PERIOD(SLOW_PERIOD)) slowGen (.clk(clk), .rst(rst), .tick(slowTick));
  msm_sync stopIn (.clk(clk), .rst(rst), .pinIn(forcedStopPin), .levelOut(stopSync));

  // slow operation cycles fall back to the fixed 3.5 ms refresh
  assign refreshTick = (cycleUs_ff <= 32'(FAST_LIMIT_US)) ? opCycleTick : slowTick;

  //////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so pready is tied high in the access phase
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign monIdx = {2'h0, paddr[15:2]};
  assign monHit = (monIdx >= MON_BASE_IDX) && (monIdx <= MON_LAST_IDX);
  assign monAxis = 7'(monIdx - MON_BASE_IDX) >> 2;
  assign monWord = monIdx[1:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_ff;

  // read mux, registered during setup so data is ready at the access edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= RESET_WORD;
    end else if (psel && !penable && !pwrite) begin
      if (monHit) begin
        unique case (monWord)
          AMP_TYPE_IDX: prdata_ff <= {16'h0, axis_ff[monAxis[4:0]].ampType};
          CURRENT_IDX: prdata_ff <= {16'h0, axis_ff[monAxis[4:0]].current};
          SPEED_LO_IDX: prdata_ff <= {16'h0, axis_ff[monAxis[4:0]].speed[15:0]};
          SPEED_HI_IDX: prdata_ff <= {16'h0, axis_ff[monAxis[4:0]].speed[31:16]};
        endcase
      end else begin
        unique case (paddr)
          STATUS_ADDR: prdata_ff <= {23'h0, allAxesServoOn, servoErr_ff, shown_ff};
          REQUEST_ADDR: prdata_ff <= request_ff;
          CAUSE_ADDR: prdata_ff <= {24'h0, cause_ff};
          CYCLE_ADDR: prdata_ff <= cycleUs_ff;
          DECEL_ADDR: prdata_ff <= decelUs_ff;
          default: prdata_ff <= RESET_WORD;
        endcase
      end
    end
  end

  // writable control words; the status and monitor words ignore writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_ff <= RESET_WORD;
      cycleUs_ff <= CYCLE_RESET_US;
      decelUs_ff <= DECEL_RESET_US;
    end else if (wrEn) begin
      unique case (paddr)
        REQUEST_ADDR: request_ff <= pwdata;
        CYCLE_ADDR: cycleUs_ff <= pwdata;
        DECEL_ADDR: decelUs_ff <= pwdata;
        default: request_ff <= request_ff;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // servo monitor records
  for (genvar a = 0; a < NUM_AXES; a++) begin : gAxis
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        axis_ff[a] <= '0;
      end else begin
        if (ampPowerOn[a]) begin
          axis_ff[a].ampType <= ampTypeIn[a*16 +: 16];
        end
        if (refreshTick) begin
          axis_ff[a].current <= currentIn[a*16 +: 16];
          axis_ff[a].speed <= speedIn[a*32 +: 32];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ready sequence; host ready follows request bit zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostReady_ff <= 1'b0;
      readyCheck_ff <= 1'b0;
    end else begin
      hostReady_ff <= request_ff[REQ_READY_BIT];
      readyCheck_ff <= request_ff[REQ_READY_BIT] && !hostReady_ff;
    end
  end

  // parameter write and machine-code clear pulse on the ready edge
  assign servoParamWrite = readyCheck_ff;
  assign mcodeClear = readyCheck_ff;

  //////////////////////////////////////////////////////////////////////////
  // live flags track events every cycle; error flags are sticky until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_ff <= '0;
      cause_ff <= 8'h0;
    end else begin
      if (events.wdogErr) begin
        live_ff[WDOG_BIT] <= 1'b1;
        cause_ff <= events.wdogCause;
      end
      if (!request_ff[REQ_READY_BIT]) begin
        live_ff[READY_BIT] <= 1'b0;
      end else if (readyCheck_ff && !events.paramErr) begin
        live_ff[READY_BIT] <= 1'b1;
      end
      live_ff[TEST_BIT] <= events.testActive;
      live_ff[FSTOP_BIT] <= !stopSync;
      if (events.handwheelErr) begin
        live_ff[HWHEEL_BIT] <= 1'b1;
      end
      if (events.testReq && events.testActive) begin
        live_ff[TESTERR_BIT] <= 1'b1;
      end
      if (events.progErr) begin
        live_ff[PROGERR_BIT] <= 1'b1;
      end
    end
  end

  // host-visible copy refreshed once per main cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shown_ff <= '0;
    end else if (mainTick) begin
      shown_ff <= live_ff;
    end
  end

  // hard stop as soon as a watchdog error is seen, no ramp
  assign immediateStop = live_ff[WDOG_BIT] || events.wdogErr;

  //////////////////////////////////////////////////////////////////////////
  // forced stop: ramp timer, servo-off and feed restore
  assign decelCycles = 32'(decelUs_ff * 32'(CYC_PER_US));
  assign stopEdge = stopSync && !prevStop_ff;
  assign releaseEdge = !stopSync && prevStop_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevStop_ff <= 1'b0;
      stopActive_ff <= 1'b0;
      decelCnt_ff <= 32'h0;
      feedHold_ff <= 32'h0;
    end else begin
      prevStop_ff <= stopSync;
      if (stopEdge && events.axesMoving) begin
        stopActive_ff <= 1'b1;
        decelCnt_ff <= 32'h0;
        feedHold_ff <= feedIn;
      end else if (stopActive_ff && releaseEdge) begin
        stopActive_ff <= 1'b0;
      end else if (stopActive_ff && decelCnt_ff < decelCycles) begin
        decelCnt_ff <= decelCnt_ff + 32'h1;
      end
    end
  end

  // feed keeps advancing during the ramp, then snaps back to the held value;
  // the counter saturates, so the restored value stands until the stop is released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feedRestore <= 1'b0;
      feedOut <= 32'h0;
    end else begin
      feedRestore <= stopActive_ff && !releaseEdge && (decelCnt_ff >= decelCycles);
      feedOut <= (stopActive_ff && decelCnt_ff >= decelCycles) ? feedHold_ff : feedIn;
    end
  end

  // early release is a servo error; sticky until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      servoErr_ff <= 1'b0;
    end else if (stopActive_ff && releaseEdge && decelCnt_ff < decelCycles) begin
      servoErr_ff <= 1'b1;
    end
  end

  // servo-on follows the host request, forced off by a stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      allAxesServoOn <= 1'b0;
    end else begin
      allAxesServoOn <= request_ff[REQ_SERVOON_BIT] && !stopSync && !stopActive_ff;
    end
  end
endmodule // motion_status_monitor

// >>> test/msm_monitor.sv
// msm_monitor: port-level checks for the motion status monitor
// assumes it is bound into motion_status_monitor and sees only its ports
`timescale 1ns/1ps
module msm_monitor import msm_pkg::*; #(
  parameter int MAIN_PERIOD = 50,
  parameter int SLOW_PERIOD = 200,
  parameter int CYC_PER_US = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and control
  input wire msm_events_s events,
  input wire logic forcedStopPin,
  input wire logic immediateStop,
  input wire logic servoParamWrite,
  input wire logic mcodeClear,
  input wire logic allAxesServoOn,
  input wire logic [31:0] feedOut,
  input wire logic feedRestore
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic reqRdy_ff;
  logic wrReq;
  ////////////////////////////////////////////////////////////////
  // last written host ready bit, so a rising edge can be told from a rewrite
  assign wrReq = psel && penable && pready && pwrite && paddr == REQUEST_ADDR;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) reqRdy_ff <= 1'b0;
    else if (wrReq) reqRdy_ff <= pwdata[REQ_READY_BIT];
  end
  sequence readyRise;
    wrReq && pwdata[REQ_READY_BIT] && !reqRdy_ff;
  endsequence
  sequence paramPulse;
    ##[1:4] servoParamWrite ##1 !servoParamWrite;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_ready_write: assert property (readyRise |-> paramPulse)
    else $error("no parameter write pulse after ready rise");
  chk_codes_clear: assert property (servoParamWrite |-> mcodeClear)
    else $error("code clear missing with parameter write");
  chk_wdog_stop: assert property (events.wdogErr |-> immediateStop)
    else $error("watchdog error without immediate stop");
  chk_stop_latch: assert property (immediateStop |=> immediateStop)
    else $error("immediate stop dropped before reset");
  chk_stop_cause: assert property ($rose(immediateStop) |-> events.wdogErr)
    else $error("immediate stop without watchdog error");
  chk_servo_off: assert property ((forcedStopPin && events.axesMoving) [*6] |-> !allAxesServoOn)
    else $error("servo-on kept during forced stop");
  chk_restore_hold: assert property (feedRestore && $past(feedRestore) |-> $stable(feedOut))
    else $error("restored feed value moved");
  chk_zero_wait: assert property (psel && !penable |=> pready && !pslverr)
    else $error("access phase not answered at once");
  chk_reset_clear: assert property ($fell(rst) |-> !immediateStop && !feedRestore && !allAxesServoOn)
    else $error("control outputs not clear after reset");
endmodule // msm_monitor

bind motion_status_monitor msm_monitor #(.MAIN_PERIOD(MAIN_PERIOD), .SLOW_PERIOD(SLOW_PERIOD),
  .CYC_PER_US(CYC_PER_US)) i_msm_monitor (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .events(events), .forcedStopPin(forcedStopPin),
  .immediateStop(immediateStop), .servoParamWrite(servoParamWrite), .mcodeClear(mcodeClear),
  .allAxesServoOn(allAxesServoOn), .feedOut(feedOut), .feedRestore(feedRestore));

// >>> test/msm_servo_model.sv
// msm_servo_model: servo amplifiers supplying operation-cycle readings
// assumes the bench seeds the random generator before the first clock edge
`timescale 1ns/1ps
module msm_servo_model import msm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // servo-side readings
  output logic opCycleTick,
  output logic [NUM_AXES*16-1:0] currentIn,
  output logic [NUM_AXES*32-1:0] speedIn
);
  int cnt = 0;
  // quiet start so no input is unknown at time zero
  initial begin
    opCycleTick = 1'b0;
    currentIn = '0;
    speedIn = '0;
  end
  // new readings mid-cycle, so a value sampled at the tick stays put for reads
  always @(posedge clk) begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    opCycleTick <= (cnt == 0);
    if (cnt == 10) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        currentIn[a*16 +: 16] <= 16'($urandom);
        speedIn[a*32 +: 32] <= $urandom;
      end
    end
  end
endmodule // msm_servo_model

// >>> test/tb.sv
// tb: self-checking bench for motion_status_monitor with a servo-side model
// assumes short main and slow periods and one clock per microsecond of decel
`timescale 1ns/1ps
module tb import msm_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] feedIn = 32'h0000_0000;
  logic [31:0] prdata, feedOut, f0, sp;
  logic pready, pslverr, immediateStop, servoParamWrite, mcodeClear, allAxesServoOn, feedRestore;
  logic [NUM_AXES-1:0] ampPowerOn = '0;
  logic [NUM_AXES*16-1:0] ampTypeIn = '0;
  logic [NUM_AXES*16-1:0] currentIn;
  logic [NUM_AXES*32-1:0] speedIn;
  logic opCycleTick;
  logic forcedStopPin = 1'b0;
  logic [7:0] c;
  msm_events_s ev = '0;
  logic [63:0] expQ[$];
  logic [63:0] e;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int ax;
  always #2.5 clk = ~clk;
  motion_status_monitor #(.MAIN_PERIOD(50), .SLOW_PERIOD(200), .CYC_PER_US(1))
    i_motion_status_monitor (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ampPowerOn(ampPowerOn), .ampTypeIn(ampTypeIn), .currentIn(currentIn),
    .speedIn(speedIn), .opCycleTick(opCycleTick), .events(ev), .forcedStopPin(forcedStopPin),
    .feedIn(feedIn), .immediateStop(immediateStop), .servoParamWrite(servoParamWrite),
    .mcodeClear(mcodeClear), .allAxesServoOn(allAxesServoOn), .feedOut(feedOut),
    .feedRestore(feedRestore));
  msm_servo_model i_msm_servo_model (.clk(clk), .rst(rst), .opCycleTick(opCycleTick),
    .currentIn(currentIn), .speedIn(speedIn));
  ////////////////////////////////////////////////////////////////
  task cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one apb transfer, held until pready is seen high, then an idle edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1); // only the hang guard ends a wait
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m);
    expQ.push_back({m, x});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [15:0] mon(input int a, input int w);
    return 16'((MON_BASE_IDX + 16'(a * WORDS_PER_AXIS + w)) * 4);
  endfunction
  task rstPulse;
    rst <= 1'b1;
    tick(8);
    rst <= 1'b0;
  endtask
  // read results are taken at the completing edge, oldest note first
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e = expQ.pop_front();
      cmp(prdata, e[31:0], e[63:32]);
    end
  end
  // hang guard, far above the roughly 1300 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    sp = $urandom(67367);
    rstPulse();
    rd(STATUS_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(CAUSE_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(CYCLE_ADDR, CYCLE_RESET_US, 32'hFFFF_FFFF);
    rd(mon(31, SPEED_HI_IDX), 32'h0000_0000, 32'hFFFF_FFFF);
    rd(16'h0100, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
    apb(1'b1, CAUSE_ADDR, 32'hFFFF_FFFF);
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0000_01F7);
    rd(CAUSE_ADDR, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, DECEL_ADDR, 32'h0000_0014);
    rd(DECEL_ADDR, 32'h0000_0014, 32'hFFFF_FFFF);
    // type words load only at power-on and then hold
    for (int i = 0; i < 3; i++) begin
      ax = (i == 0) ? 0 : (i == 1) ? 31 : 6 + $urandom_range(24);
      ampTypeIn[ax*16 +: 16] <= 16'h2000 + 16'(ax);
      ampPowerOn[ax] <= 1'b1;
      tick(1);
      ampPowerOn[ax] <= 1'b0;
      ampTypeIn[ax*16 +: 16] <= 16'h0000;
      tick(2);
      rd(mon(ax, AMP_TYPE_IDX), 32'h0000_2000 + 32'(ax), 32'hFFFF_FFFF);
    end
    rd(mon(5, AMP_TYPE_IDX), 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, mon(0, AMP_TYPE_IDX), 32'h0000_FFFF);
    rd(mon(0, AMP_TYPE_IDX), 32'h0000_2000, 32'hFFFF_FFFF);
    // current and speed follow the operation cycle tick
    for (int i = 0; i < 2; i++) begin
      ax = (i == 0) ? 31 : $urandom_range(30);
      do @(posedge clk); while (opCycleTick !== 1'b1);
      f0 = {16'h0000, currentIn[ax*16 +: 16]};
      sp = speedIn[ax*32 +: 32];
      rd(mon(ax, CURRENT_IDX), f0, 32'hFFFF_FFFF);
      rd(mon(ax, SPEED_LO_IDX), {16'h0000, sp[15:0]}, 32'hFFFF_FFFF);
      rd(mon(ax, SPEED_HI_IDX), {16'h0000, sp[31:16]}, 32'hFFFF_FFFF);
    end
    // ready rise is refused on a parameter error, then accepted
    ev.paramErr <= 1'b1;
    apb(1'b1, REQUEST_ADDR, 32'h0000_0001);
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0000_0002);
    apb(1'b1, REQUEST_ADDR, 32'h0000_0000);
    ev.paramErr <= 1'b0;
    apb(1'b1, REQUEST_ADDR, 32'h0000_0003);
    tick(120);
    rd(STATUS_ADDR, 32'h0000_010A, 32'h0000_010A);
    rd(REQUEST_ADDR, 32'h0000_0003, 32'h0000_0003);
    // test request counts as an error only while test mode is on
    ev.testReq <= 1'b1;
    tick(1);
    ev.testReq <= 1'b0;
    ev.testActive <= 1'b1;
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0004, 32'h0000_0024);
    ev.testReq <= 1'b1;
    tick(1);
    ev.testReq <= 1'b0;
    ev.testActive <= 1'b0;
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0020, 32'h0000_0024);
    ev.handwheelErr <= 1'b1;
    ev.progErr <= 1'b1;
    tick(1);
    ev.handwheelErr <= 1'b0;
    ev.progErr <= 1'b0;
    apb(1'b1, REQUEST_ADDR, 32'h0000_0002);
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0050, 32'h0000_0052);
    // forced stop held past the decel time restores the feed value
    f0 = $urandom;
    ev.axesMoving <= 1'b1;
    feedIn <= f0;
    forcedStopPin <= 1'b1;
    tick(12);
    feedIn <= f0 + 32'h0000_0064;
    tick(40);
    cmp(32'(feedRestore), 32'h0000_0001, 32'h0000_0001);
    cmp(feedOut, f0, 32'hFFFF_FFFF);
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0000_0188);
    forcedStopPin <= 1'b0;
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0008, 32'h0000_0088);
    // an early release is a servo error
    forcedStopPin <= 1'b1;
    tick(10);
    forcedStopPin <= 1'b0;
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0088, 32'h0000_0088);
    ev.axesMoving <= 1'b0;
    // watchdog error stops at once, sets flag and cause; reset clears them
    c = 8'(1 + $urandom_range(254));
    ev.wdogCause <= c;
    ev.wdogErr <= 1'b1;
    tick(1);
    ev.wdogErr <= 1'b0;
    tick(2);
    cmp(32'(immediateStop), 32'h0000_0001, 32'h0000_0001);
    tick(120);
    rd(STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
    rd(CAUSE_ADDR, 32'(c), 32'h0000_00FF);
    rstPulse();
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0000_01FF);
    cmp(32'(immediateStop), 32'h0000_0000, 32'h0000_0001);
    conclude();
  end
endmodule // tb
